// ### shared/bank_fsm_pkg.sv
// Package with command codes, bank states and timing constants for the bank command machine
package bank_fsm_pkg;
   // Decoded command kinds
   typedef enum logic [3:0] {
      cmd_deselect = 4'h0,
      cmd_nop = 4'h1,
      cmd_read = 4'h2,
      cmd_write = 4'h3,
      cmd_row_open = 4'h4,
      cmd_close = 4'h5,
      cmd_refresh = 4'h6,
      cmd_mode_set = 4'h7
   } cmd_t;

   // Bank states, one-hot
   typedef enum logic [10:0] {
      st_idle = 11'h001,
      st_row_activating = 11'h002,
      st_active = 11'h004,
      st_read = 11'h008,
      st_write = 11'h010,
      st_read_autoclose = 11'h020,
      st_write_autoclose = 11'h040,
      st_precharging = 11'h080,
      st_write_recovering = 11'h100,
      st_write_recovering_ac = 11'h200,
      st_refreshing = 11'h400
   } bank_state_t;

   // Times in ns
   localparam int CLK_PERIOD_NS = 40;
   localparam int PRECHARGE_PERIOD_NS = 15;
   localparam int ACTIVATE_TO_COLUMN_DELAY_NS = 15;
   localparam int WRITE_RECOVERY_TIME_NS = 15;
   localparam int REFRESH_CYCLE_TIME_NS = 195;
   localparam int MODE_SET_DELAY_NS = 80;

   // Least times rounded up to cycles, at least one
   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction : ns_to_cyc

   localparam int PRECHARGE_PERIOD_CYC = ns_to_cyc(PRECHARGE_PERIOD_NS);
   localparam int ACTIVATE_TO_COLUMN_DELAY_CYC = ns_to_cyc(ACTIVATE_TO_COLUMN_DELAY_NS);
   localparam int WRITE_RECOVERY_TIME_CYC = ns_to_cyc(WRITE_RECOVERY_TIME_NS);
   localparam int REFRESH_CYCLE_TIME_CYC = ns_to_cyc(REFRESH_CYCLE_TIME_NS);
   localparam int MODE_SET_DELAY_CYC = ns_to_cyc(MODE_SET_DELAY_NS);

   localparam int BANK_COUNT = 8;
   localparam int BANK_ADDR_W = 3;
   localparam int TIMER_W = 8;
   localparam int BURST_LEN_DEFAULT = 8;
   localparam int BEATS_PER_CYCLE = 2;
endpackage : bank_fsm_pkg

// ### shared/cmd_bus_if.sv
// Interface carrying a decoded command from the decoder to the bank machines
`timescale 1ns/10ps
interface cmd_bus_if;
   bank_fsm_pkg::cmd_t cmd;
   logic [bank_fsm_pkg::BANK_ADDR_W-1:0] bank;
   logic autoclose_all_bit;
   logic cke_now;
   logic cke_prev;
   modport source (output cmd, bank, autoclose_all_bit, cke_now, cke_prev);
   modport sink (input cmd, bank, autoclose_all_bit, cke_now, cke_prev);
endinterface : cmd_bus_if

// ### rtl/cmd_decoder.sv
// Command decoder from chip select, row strobe, column strobe and write enable
`timescale 1ns/10ps
module cmd_decoder (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Command pins sampled at the rising edge
   input wire logic chip_select_n,
   input wire logic row_strobe_n,
   input wire logic column_strobe_n,
   input wire logic write_enable_n,
   input wire logic clock_enable,
   input wire logic [bank_fsm_pkg::BANK_ADDR_W-1:0] bank_addr,
   input wire logic autoclose_all_bit,
   // Decoded command
   cmd_bus_if.source bus
);
   typedef struct packed {
      logic cke_prev;
   } dec_state_t;

   dec_state_t cur_ff;
   dec_state_t nxt_cur;

   always_comb begin
      nxt_cur.cke_prev = clock_enable;
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cur_ff <= '{cke_prev: 1'b1};
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   always_comb begin
      if (chip_select_n) begin
         bus.cmd = bank_fsm_pkg::cmd_deselect;
      end else begin
         case ({row_strobe_n, column_strobe_n, write_enable_n})
            3'h7: bus.cmd = bank_fsm_pkg::cmd_nop;
            3'h5: bus.cmd = bank_fsm_pkg::cmd_read;
            3'h4: bus.cmd = bank_fsm_pkg::cmd_write;
            3'h3: bus.cmd = bank_fsm_pkg::cmd_row_open;
            3'h2: bus.cmd = bank_fsm_pkg::cmd_close;
            3'h1: bus.cmd = bank_fsm_pkg::cmd_refresh;
            3'h0: bus.cmd = bank_fsm_pkg::cmd_mode_set;
            default: bus.cmd = bank_fsm_pkg::cmd_nop;
         endcase
      end
   end

   assign bus.bank = bank_addr;
   assign bus.autoclose_all_bit = autoclose_all_bit;
   assign bus.cke_now = clock_enable;
   assign bus.cke_prev = cur_ff.cke_prev;
endmodule : cmd_decoder

// ### rtl/sdram_bank_command_state_machine.sv
// Per-bank command state machine of a double-data-rate synchronous DRAM
// Operation
// - Commands decode from select, strobes, write enable and clock enable at rising edge.
// - Precharge from idle or active closes addressed bank, or all with autoclose bit.
// - Refresh in idle is auto refresh with enable high, self refresh with it low.
// - Activated bank accepts only deselect or nop, becomes active after delay.
// - Open row plus read command starts read burst, with or without autoclose.
// - Open row plus write command starts write burst, with or without autoclose.
// - Deselect or nop lets any burst run to its last beat.
// - Read interrupts plain read burst; other commands during read are illegal.
// - Write interrupts plain write burst; other commands during write are illegal.
// - Precharging accepts deselect, nop, precharge; idle after precharge period.
// - Write recovery after plain write returns to active after recovery time.
// - Write recovery after plain write accepts new write; others illegal.
// - Autoclose write recovery accepts only deselect or nop, then precharges.
// - Auto refresh accepts only deselect or nop, idle after refresh cycle time.
// - Mode set accepts only deselect or nop, idle after mode set delay.
`timescale 1ns/10ps
module sdram_bank_command_state_machine #(
   parameter int BURST_LEN = bank_fsm_pkg::BURST_LEN_DEFAULT
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Command pins
   input wire logic chip_select_n,
   input wire logic row_strobe_n,
   input wire logic column_strobe_n,
   input wire logic write_enable_n,
   input wire logic clock_enable,
   input wire logic [bank_fsm_pkg::BANK_ADDR_W-1:0] bank_addr,
   input wire logic autoclose_all_bit,
   // Bank status
   output logic [bank_fsm_pkg::BANK_COUNT-1:0] bank_idle,
   output logic [bank_fsm_pkg::BANK_COUNT-1:0] bank_open,
   output logic [bank_fsm_pkg::BANK_COUNT-1:0] bank_bursting,
   output logic mode_reg_busy,
   output logic self_refresh,
   output logic power_down,
   output logic illegal_cmd
);
   localparam int NB = bank_fsm_pkg::BANK_COUNT;
   localparam int TW = bank_fsm_pkg::TIMER_W;
   localparam logic [TW-1:0] BURST_CYC = TW'(BURST_LEN / bank_fsm_pkg::BEATS_PER_CYCLE);

   cmd_bus_if bus ();

   cmd_decoder u_dec (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .chip_select_n(chip_select_n),
      .row_strobe_n(row_strobe_n),
      .column_strobe_n(column_strobe_n),
      .write_enable_n(write_enable_n),
      .clock_enable(clock_enable),
      .bank_addr(bank_addr),
      .autoclose_all_bit(autoclose_all_bit),
      .bus(bus.source)
   );

   typedef struct packed {
      bank_fsm_pkg::bank_state_t [NB-1:0] st;
      logic [NB-1:0][TW-1:0] tmr;
      logic [TW-1:0] mrs_tmr;
      logic self_ref;
      logic pdown;
      logic illegal;
      logic [NB-1:0] idle_o;
      logic [NB-1:0] open_o;
      logic [NB-1:0] burst_o;
      logic mrs_o;
   } core_t;

   core_t cur_ff;
   core_t nxt_cur;

   function automatic logic [TW-1:0] cyc(input int n);
      return TW'(n);
   endfunction : cyc

   function automatic logic quiet(input bank_fsm_pkg::cmd_t c);
      return (c == bank_fsm_pkg::cmd_deselect) || (c == bank_fsm_pkg::cmd_nop);
   endfunction : quiet

   always_comb begin
      logic all_idle;
      logic hit;
      logic live;
      logic timed_out;
      bank_fsm_pkg::cmd_t c;
      all_idle = 1'b0;
      hit = 1'b0;
      live = 1'b0;
      timed_out = 1'b0;
      c = bus.cmd;
      nxt_cur = cur_ff;
      nxt_cur.illegal = 1'b0;
      // Commands apply only in normal operation
      live = !(cur_ff.self_ref || cur_ff.pdown || !bus.cke_now || cur_ff.mrs_tmr != '0);
      all_idle = (cur_ff.mrs_tmr == '0) && !cur_ff.self_ref;
      for (int b = 0; b < NB; b++) begin
         all_idle = all_idle && (cur_ff.st[b] == bank_fsm_pkg::st_idle);
      end
      // Self refresh and power-down hold until clock enable returns
      if (cur_ff.self_ref || cur_ff.pdown) begin
         if (bus.cke_now) begin
            nxt_cur.self_ref = 1'b0;
            nxt_cur.pdown = 1'b0;
         end
      end else if (bus.cke_prev && !bus.cke_now) begin
         if (c == bank_fsm_pkg::cmd_refresh && all_idle) begin
            nxt_cur.self_ref = 1'b1;
         end else if (quiet(c)) begin
            nxt_cur.pdown = 1'b1;
         end else begin
            nxt_cur.illegal = 1'b1;
         end
      end else if (cur_ff.mrs_tmr != '0) begin
         nxt_cur.mrs_tmr = cur_ff.mrs_tmr - cyc(1);
         if (!quiet(c)) begin
            nxt_cur.illegal = 1'b1;
         end
      end else if (c == bank_fsm_pkg::cmd_mode_set) begin
         if (all_idle) begin
            nxt_cur.mrs_tmr = cyc(bank_fsm_pkg::MODE_SET_DELAY_CYC);
         end else begin
            nxt_cur.illegal = 1'b1;
         end
      end
      for (int b = 0; b < NB; b++) begin
         hit = (bus.bank == (bank_fsm_pkg::BANK_ADDR_W)'(b));
         timed_out = (cur_ff.tmr[b] <= cyc(1));
         if (cur_ff.tmr[b] != '0) begin
            nxt_cur.tmr[b] = cur_ff.tmr[b] - cyc(1);
         end
         if (!live) begin
            hit = 1'b0;
         end
         case (cur_ff.st[b])
            bank_fsm_pkg::st_idle: begin
               if (hit && c == bank_fsm_pkg::cmd_row_open) begin
                  nxt_cur.st[b] = bank_fsm_pkg::st_row_activating;
                  nxt_cur.tmr[b] = cyc(bank_fsm_pkg::ACTIVATE_TO_COLUMN_DELAY_CYC);
               end else if (c == bank_fsm_pkg::cmd_refresh && all_idle && bus.cke_now && !cur_ff.pdown) begin
                  nxt_cur.st[b] = bank_fsm_pkg::st_refreshing;
                  nxt_cur.tmr[b] = cyc(bank_fsm_pkg::REFRESH_CYCLE_TIME_CYC);
               end else if (hit && (c == bank_fsm_pkg::cmd_read || c == bank_fsm_pkg::cmd_write)) begin
                  nxt_cur.illegal = 1'b1;
               end
            end
            bank_fsm_pkg::st_row_activating: begin
               if (timed_out) begin
                  nxt_cur.st[b] = bank_fsm_pkg::st_active;
               end
               if (hit && !quiet(c)) begin
                  nxt_cur.illegal = 1'b1;
               end
            end
            bank_fsm_pkg::st_active, bank_fsm_pkg::st_write_recovering, bank_fsm_pkg::st_read,
            bank_fsm_pkg::st_write: begin
               if (cur_ff.st[b] != bank_fsm_pkg::st_active && timed_out) begin
                  if (cur_ff.st[b] == bank_fsm_pkg::st_write) begin
                     nxt_cur.st[b] = bank_fsm_pkg::st_write_recovering;
                     nxt_cur.tmr[b] = cyc(bank_fsm_pkg::WRITE_RECOVERY_TIME_CYC);
                  end else begin
                     nxt_cur.st[b] = bank_fsm_pkg::st_active;
                  end
               end
               if (hit && c == bank_fsm_pkg::cmd_read && cur_ff.st[b] inside {bank_fsm_pkg::st_active,
                     bank_fsm_pkg::st_read}) begin
                  nxt_cur.st[b] = bus.autoclose_all_bit ? bank_fsm_pkg::st_read_autoclose
                     : bank_fsm_pkg::st_read;
                  nxt_cur.tmr[b] = BURST_CYC;
               end else if (hit && c == bank_fsm_pkg::cmd_write && cur_ff.st[b] != bank_fsm_pkg::st_read) begin
                  nxt_cur.st[b] = bus.autoclose_all_bit ? bank_fsm_pkg::st_write_autoclose
                     : bank_fsm_pkg::st_write;
                  nxt_cur.tmr[b] = BURST_CYC;
               end else if (c == bank_fsm_pkg::cmd_close && (hit || (live && bus.autoclose_all_bit))
                     && cur_ff.st[b] == bank_fsm_pkg::st_active) begin
                  nxt_cur.st[b] = bank_fsm_pkg::st_precharging;
                  nxt_cur.tmr[b] = cyc(bank_fsm_pkg::PRECHARGE_PERIOD_CYC);
               end else if (hit && !quiet(c)) begin
                  nxt_cur.illegal = 1'b1;
               end
            end
            bank_fsm_pkg::st_read_autoclose, bank_fsm_pkg::st_write_autoclose: begin
               if (timed_out) begin
                  if (cur_ff.st[b] == bank_fsm_pkg::st_write_autoclose) begin
                     nxt_cur.st[b] = bank_fsm_pkg::st_write_recovering_ac;
                     nxt_cur.tmr[b] = cyc(bank_fsm_pkg::WRITE_RECOVERY_TIME_CYC);
                  end else begin
                     nxt_cur.st[b] = bank_fsm_pkg::st_precharging;
                     nxt_cur.tmr[b] = cyc(bank_fsm_pkg::PRECHARGE_PERIOD_CYC);
                  end
               end
               if (hit && !quiet(c)) begin
                  nxt_cur.illegal = 1'b1;
               end
            end
            bank_fsm_pkg::st_write_recovering_ac: begin
               if (timed_out) begin
                  nxt_cur.st[b] = bank_fsm_pkg::st_precharging;
                  nxt_cur.tmr[b] = cyc(bank_fsm_pkg::PRECHARGE_PERIOD_CYC);
               end
               if (hit && !quiet(c)) begin
                  nxt_cur.illegal = 1'b1;
               end
            end
            bank_fsm_pkg::st_precharging: begin
               if (timed_out) begin
                  nxt_cur.st[b] = bank_fsm_pkg::st_idle;
               end
               if (hit && !quiet(c) && c != bank_fsm_pkg::cmd_close) begin
                  nxt_cur.illegal = 1'b1;
               end
            end
            bank_fsm_pkg::st_refreshing: begin
               if (timed_out) begin
                  nxt_cur.st[b] = bank_fsm_pkg::st_idle;
               end
               if (!quiet(c) && bus.cke_now) begin
                  nxt_cur.illegal = 1'b1;
               end
            end
            default: begin
               nxt_cur.st[b] = bank_fsm_pkg::st_idle;
               nxt_cur.tmr[b] = '0;
            end
         endcase
         // Precharge to an idle bank, single or all, is a no-op
         if (c == bank_fsm_pkg::cmd_close && cur_ff.st[b] == bank_fsm_pkg::st_idle) begin
            nxt_cur.st[b] = bank_fsm_pkg::st_idle;
         end
         nxt_cur.idle_o[b] = (nxt_cur.st[b] == bank_fsm_pkg::st_idle);
         nxt_cur.open_o[b] = !(nxt_cur.st[b] inside {bank_fsm_pkg::st_idle, bank_fsm_pkg::st_precharging,
            bank_fsm_pkg::st_refreshing});
         nxt_cur.burst_o[b] = nxt_cur.st[b] inside {bank_fsm_pkg::st_read, bank_fsm_pkg::st_write,
            bank_fsm_pkg::st_read_autoclose, bank_fsm_pkg::st_write_autoclose};
      end
      nxt_cur.mrs_o = (nxt_cur.mrs_tmr != '0);
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         for (int b = 0; b < NB; b++) begin
            cur_ff.st[b] <= bank_fsm_pkg::st_idle;
            cur_ff.tmr[b] <= '0;
         end
         cur_ff.mrs_tmr <= '0;
         cur_ff.self_ref <= 1'b0;
         cur_ff.pdown <= 1'b0;
         cur_ff.illegal <= 1'b0;
         cur_ff.idle_o <= '1;
         cur_ff.open_o <= '0;
         cur_ff.burst_o <= '0;
         cur_ff.mrs_o <= 1'b0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign bank_idle = cur_ff.idle_o;
   assign bank_open = cur_ff.open_o;
   assign bank_bursting = cur_ff.burst_o;
   assign mode_reg_busy = cur_ff.mrs_o;
   assign self_refresh = cur_ff.self_ref;
   assign power_down = cur_ff.pdown;
   assign illegal_cmd = cur_ff.illegal;
endmodule : sdram_bank_command_state_machine

// ### testbench/ddr_ctrl_model.sv
// Controller model driving the command pins, one command per clock edge
`timescale 1ns/10ps
module ddr_ctrl_model (
   // Clock
   input wire logic clk_sys,
   // Command pins
   output logic chip_select_n,
   output logic row_strobe_n,
   output logic column_strobe_n,
   output logic write_enable_n,
   output logic clock_enable,
   output logic [bank_fsm_pkg::BANK_ADDR_W-1:0] bank_addr,
   output logic autoclose_all_bit
);
   initial begin
      {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = 4'hF;
      clock_enable = 1'b1;
      bank_addr = 3'h0;
      autoclose_all_bit = 1'b0;
   end
   // Callers also send commands the addressed bank refuses
   task automatic issue(input bank_fsm_pkg::cmd_t c, input logic [2:0] b, input logic a, input logic e);
      @(posedge clk_sys);
      #1;
      clock_enable = e;
      bank_addr = (c == bank_fsm_pkg::cmd_deselect) ? ~b : b;
      autoclose_all_bit = a;
      case (c)
         bank_fsm_pkg::cmd_nop: {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = 4'h7;
         bank_fsm_pkg::cmd_read: {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = 4'h5;
         bank_fsm_pkg::cmd_write: {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = 4'h4;
         bank_fsm_pkg::cmd_row_open: {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = 4'h3;
         bank_fsm_pkg::cmd_close: {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = 4'h2;
         bank_fsm_pkg::cmd_refresh: {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = 4'h1;
         bank_fsm_pkg::cmd_mode_set: {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = 4'h0;
         default: begin
            // Unselected: the other pins carry no meaning, so they toggle
            chip_select_n = 1'b1;
            {row_strobe_n, column_strobe_n, write_enable_n} = ~{row_strobe_n, column_strobe_n, write_enable_n};
         end
      endcase
   endtask : issue
endmodule : ddr_ctrl_model

// ### testbench/bank_fsm_assertions.sv
// Checker of the bank command machine at its ports
`timescale 1ns/10ps
module bank_fsm_assertions (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Command pins
   input wire logic chip_select_n,
   input wire logic row_strobe_n,
   input wire logic column_strobe_n,
   input wire logic write_enable_n,
   input wire logic clock_enable,
   input wire logic [bank_fsm_pkg::BANK_ADDR_W-1:0] bank_addr,
   input wire logic autoclose_all_bit,
   // Bank status
   input wire logic [bank_fsm_pkg::BANK_COUNT-1:0] bank_idle,
   input wire logic [bank_fsm_pkg::BANK_COUNT-1:0] bank_open,
   input wire logic [bank_fsm_pkg::BANK_COUNT-1:0] bank_bursting,
   input wire logic mode_reg_busy,
   input wire logic self_refresh,
   input wire logic power_down,
   input wire logic illegal_cmd
);
   logic [3:0] pins;
   logic quiet, rd, act, pre, rf, ms, calm;
   assign pins = {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n};
   assign quiet = chip_select_n || pins == 4'h7;
   assign rd = pins == 4'h5;
   assign act = pins == 4'h3;
   assign pre = pins == 4'h2;
   assign rf = pins == 4'h1;
   assign ms = pins == 4'h0;
   assign calm = bank_idle == 8'hFF && !mode_reg_busy && !self_refresh && !power_down;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   a_act_opens_bank: assert property (act && calm && clock_enable
      |=> bank_open[$past(bank_addr)] && !bank_idle[$past(bank_addr)])
      else $error("row open did not open bank");
   a_activating_quiet: assert property (act && calm && clock_enable
      ##1 act && bank_addr == $past(bank_addr) |=> illegal_cmd)
      else $error("second row open not refused");
   a_read_starts: assert property (rd && clock_enable && !power_down
      && bank_open[bank_addr] && !bank_bursting[bank_addr]
      |=> bank_bursting[$past(bank_addr)] != illegal_cmd)
      else $error("read neither started nor refused");
   a_burst_runs_out: assert property ($rose(bank_bursting[1]) |-> bank_bursting[1] [*4])
      else $error("burst cut short");
   a_close_all_banks: assert property (pre && autoclose_all_bit && clock_enable
      && bank_bursting == 8'h00 |=> (bank_open & $past(bank_open)) == 8'h00 || illegal_cmd)
      else $error("close all left a bank open");
   a_refresh_busy: assert property (rf && calm && clock_enable ##1 act |=> illegal_cmd)
      else $error("command during refresh not refused");
   a_self_entry: assert property (rf && calm && !clock_enable && $past(clock_enable) |=> self_refresh)
      else $error("self refresh not entered");
   a_mode_set_delay: assert property (ms && calm && clock_enable
      |=> mode_reg_busy ##1 mode_reg_busy ##1 !mode_reg_busy)
      else $error("mode set delay wrong");
   a_idle_stays_idle: assert property (quiet && calm && clock_enable
      && $past(clock_enable) |=> bank_idle == 8'hFF)
      else $error("quiet command changed idle banks");
   a_power_entry: assert property (quiet && calm && !clock_enable && $past(clock_enable) |=> power_down)
      else $error("power down not entered");
   c_burst: cover property (rd ##1 bank_bursting != 8'h00);
   c_refused: cover property (illegal_cmd);
   c_self: cover property ($rose(self_refresh));
   c_mode: cover property ($rose(mode_reg_busy));
endmodule : bank_fsm_assertions
bind sdram_bank_command_state_machine bank_fsm_assertions u_bank_fsm_assertions (
   .clk_sys(clk_sys), .reset_n(reset_n), .chip_select_n(chip_select_n), .row_strobe_n(row_strobe_n),
   .column_strobe_n(column_strobe_n), .write_enable_n(write_enable_n), .clock_enable(clock_enable),
   .bank_addr(bank_addr), .autoclose_all_bit(autoclose_all_bit), .bank_idle(bank_idle), .bank_open(bank_open),
   .bank_bursting(bank_bursting), .mode_reg_busy(mode_reg_busy), .self_refresh(self_refresh),
   .power_down(power_down), .illegal_cmd(illegal_cmd));

// ### testbench/sdram_bank_command_state_machine_tb_top.sv
// Self-checking bench of the bank command machine
`timescale 1ns/10ps
module sdram_bank_command_state_machine_tb_top;
   localparam bank_fsm_pkg::cmd_t dsl_c = bank_fsm_pkg::cmd_deselect;
   localparam bank_fsm_pkg::cmd_t nop_c = bank_fsm_pkg::cmd_nop;
   localparam bank_fsm_pkg::cmd_t rd_c = bank_fsm_pkg::cmd_read;
   localparam bank_fsm_pkg::cmd_t wr_c = bank_fsm_pkg::cmd_write;
   localparam bank_fsm_pkg::cmd_t act_c = bank_fsm_pkg::cmd_row_open;
   localparam bank_fsm_pkg::cmd_t pre_c = bank_fsm_pkg::cmd_close;
   localparam bank_fsm_pkg::cmd_t ref_c = bank_fsm_pkg::cmd_refresh;
   localparam bank_fsm_pkg::cmd_t ms_c = bank_fsm_pkg::cmd_mode_set;
   logic clk_sys, reset_n, chip_select_n, row_strobe_n, column_strobe_n, write_enable_n, clock_enable;
   logic autoclose_all_bit, mode_reg_busy, self_refresh, power_down, illegal_cmd;
   logic [2:0] bank_addr;
   logic [7:0] bank_idle, bank_open, bank_bursting;
   int bad_count = 0;
   int checks_done = 0;
   ddr_ctrl_model u_ddr_ctrl_model (.clk_sys(clk_sys), .chip_select_n(chip_select_n), .row_strobe_n(row_strobe_n),
      .column_strobe_n(column_strobe_n), .write_enable_n(write_enable_n), .clock_enable(clock_enable),
      .bank_addr(bank_addr), .autoclose_all_bit(autoclose_all_bit));
   sdram_bank_command_state_machine u_sdram_bank_command_state_machine (.clk_sys(clk_sys), .reset_n(reset_n),
      .chip_select_n(chip_select_n), .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
      .write_enable_n(write_enable_n), .clock_enable(clock_enable), .bank_addr(bank_addr),
      .autoclose_all_bit(autoclose_all_bit), .bank_idle(bank_idle), .bank_open(bank_open),
      .bank_bursting(bank_bursting), .mode_reg_busy(mode_reg_busy), .self_refresh(self_refresh),
      .power_down(power_down), .illegal_cmd(illegal_cmd));
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   task automatic end_of_test();
      $display("Mismatches %0d, checks %0d", bad_count, checks_done);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   // Each command is taken at the edge after the call; outputs show it after the next call
   task automatic cmd(input bank_fsm_pkg::cmd_t c, input logic [2:0] b = 3'h0, input logic a = 1'b0,
         input logic e = 1'b1);
      u_ddr_ctrl_model.issue(c, b, a, e);
   endtask : cmd
   task automatic t_read();
      int n;
      n = 0;
      cmd(act_c, 3'h2);
      cmd(rd_c, 3'h2);
      cmd(rd_c, 3'h2);
      chk(8'(illegal_cmd), 8'h01);
      cmd(wr_c, 3'h2);
      n += bank_bursting[2];
      cmd(rd_c, 3'h2);
      n += bank_bursting[2];
      chk(8'(illegal_cmd), 8'h01);
      repeat (8) begin
         cmd(nop_c);
         n += bank_bursting[2];
      end
      chk(8'(n), 8'h06);
      chk(bank_open, 8'h04);
      cmd(pre_c, 3'h2);
      cmd(pre_c, 3'h2);
      cmd(nop_c);
      chk(8'(illegal_cmd), 8'h00);
      repeat (2) cmd(dsl_c);
      chk(bank_idle, 8'hFF);
   endtask : t_read
   task automatic t_write();
      int n;
      n = 0;
      cmd(act_c, 3'h1);
      cmd(nop_c);
      cmd(wr_c, 3'h1);
      repeat (4) begin
         cmd(nop_c);
         n += bank_bursting[1];
      end
      chk(8'(n), 8'h04);
      cmd(wr_c, 3'h1);
      chk(bank_bursting, 8'h00);
      chk(bank_open, 8'h02);
      cmd(rd_c, 3'h1);
      chk(bank_bursting, 8'h02);
      chk(8'(illegal_cmd), 8'h00);
      cmd(wr_c, 3'h1);
      chk(8'(illegal_cmd), 8'h01);
      cmd(nop_c);
      chk(8'(illegal_cmd), 8'h00);
      repeat (6) cmd(nop_c);
      cmd(rd_c, 3'h1);
      cmd(nop_c);
      chk(8'(illegal_cmd), 8'h00);
      chk(bank_bursting, 8'h02);
      repeat (3) cmd(nop_c);
      cmd(wr_c, 3'h1, 1'b1);
      cmd(rd_c, 3'h1);
      cmd(nop_c);
      chk(8'(illegal_cmd), 8'h01);
      repeat (8) cmd(nop_c);
      chk(bank_idle, 8'hFF);
      cmd(act_c, 3'h1);
      cmd(nop_c);
      cmd(rd_c, 3'h1, 1'b1);
      repeat (8) cmd(nop_c);
      chk(bank_idle, 8'hFF);
   endtask : t_write
   task automatic t_close();
      cmd(pre_c, 3'h5);
      cmd(act_c, 3'h0);
      cmd(act_c, 3'h3);
      chk(8'(illegal_cmd), 8'h00);
      cmd(nop_c);
      cmd(act_c, 3'h0);
      cmd(pre_c, 3'h3);
      chk(8'(illegal_cmd), 8'h01);
      repeat (3) cmd(nop_c);
      chk(bank_open, 8'h01);
      cmd(pre_c, 3'h6, 1'b1);
      repeat (3) cmd(nop_c);
      chk(bank_idle, 8'hFF);
      cmd(act_c, 3'h7);
      cmd(act_c, 3'h7);
      cmd(nop_c);
      chk(8'(illegal_cmd), 8'h01);
      cmd(pre_c, 3'h7);
      repeat (2) cmd(nop_c);
      chk(bank_idle, 8'hFF);
   endtask : t_close
   task automatic t_refresh();
      cmd(ref_c);
      cmd(act_c, 3'h4);
      cmd(nop_c);
      chk(8'(illegal_cmd), 8'h01);
      repeat (5) cmd(nop_c);
      chk(bank_idle, 8'hFF);
      cmd(ref_c, 3'h0, 1'b0, 1'b0);
      cmd(nop_c, 3'h0, 1'b0, 1'b0);
      chk(8'(self_refresh), 8'h01);
      cmd(nop_c);
      repeat (2) cmd(nop_c);
      chk(8'(self_refresh), 8'h00);
   endtask : t_refresh
   task automatic t_mode();
      cmd(ms_c);
      cmd(act_c, 3'h0);
      cmd(nop_c);
      chk(8'(illegal_cmd), 8'h01);
      chk(8'(mode_reg_busy), 8'h01);
      cmd(nop_c);
      chk(8'(mode_reg_busy), 8'h00);
      chk(bank_idle, 8'hFF);
   endtask : t_mode
   task automatic t_power();
      cmd(dsl_c, 3'h0, 1'b0, 1'b0);
      cmd(nop_c, 3'h0, 1'b0, 1'b0);
      chk(8'(power_down), 8'h01);
      chk(bank_idle, 8'hFF);
      cmd(nop_c);
      repeat (2) cmd(nop_c);
      chk(8'(power_down), 8'h00);
   endtask : t_power
   initial begin
      #100000;
      bad_count++;
      end_of_test();
   end
   initial begin
      reset_n = 1'b0;
      repeat (4) @(posedge clk_sys);
      #1;
      reset_n = 1'b1;
      chk(bank_idle, 8'hFF);
      chk(bank_open | bank_bursting, 8'h00);
      t_read();
      t_write();
      t_close();
      t_refresh();
      t_mode();
      t_power();
      end_of_test();
   end
endmodule : sdram_bank_command_state_machine_tb_top
